// >>> include/msg_unit_pkg.sv
package msg_unit_pkg;

  // Shared RAM geometry: 96 Kbyte of 32-bit words
  localparam int RAM_KBYTES    = 96;
  localparam int WORD_BYTES    = 4;
  localparam int RAM_WORDS_DEF = RAM_KBYTES * 1024 / WORD_BYTES;
  localparam int Q_DEPTH_DEF   = 128;
  localparam int NUM_QUEUES    = 3;
  localparam int QUEUE_SLOTS   = 4;
  localparam int DATA_W        = 32;

  // Queue numbering; also the slot order of the queue region in RAM
  localparam logic [1:0] Q_REQ_POST   = 2'h0;
  localparam logic [1:0] Q_REPLY_POST = 2'h1;
  localparam logic [1:0] Q_REPLY_FREE = 2'h2;

  // Host-side register offsets, same in memory space and I/O window
  localparam logic [7:0] HOFF_DOORBELL   = 8'h00;
  localparam logic [7:0] HOFF_STATUS     = 8'h04;
  localparam logic [7:0] HOFF_MASK       = 8'h08;
  localparam logic [7:0] HOFF_REQ_POST   = 8'h0C;
  localparam logic [7:0] HOFF_REPLY_POST = 8'h10;
  localparam logic [7:0] HOFF_REPLY_FREE = 8'h14;
  localparam logic [7:0] HOFF_COALESCE   = 8'h18;

  // I/O processor register offsets
  localparam logic [7:0] IOFF_DOORBELL   = 8'h00;
  localparam logic [7:0] IOFF_STATUS     = 8'h04;
  localparam logic [7:0] IOFF_MASK       = 8'h08;
  localparam logic [7:0] IOFF_REQ_POST   = 8'h0C;
  localparam logic [7:0] IOFF_REPLY_CTX  = 8'h10;
  localparam logic [7:0] IOFF_REPLY_ADDR = 8'h14;
  localparam logic [7:0] IOFF_REPLY_FREE = 8'h18;
  localparam logic [7:0] IOFF_LEVELS     = 8'h1C;

  // Status and mask bit positions
  localparam int ST_DB_BIT    = 0;
  localparam int ST_QUEUE_BIT = 1;

  // Coalescing control layout and reset value
  localparam int COAL_THR_LSB = 0;
  localparam int COAL_TMO_LSB = 8;
  localparam int COAL_FLD_W   = 8;
  localparam logic [15:0] COAL_RESET = 16'h0001;

  // Reply descriptor format
  localparam int REPLY_TYPE_BIT = 31;
  localparam logic [31:0] EMPTY_WORD = 32'hFFFFFFFF;

  // Coalescing timeout tick of 1 us at 250 MHz
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;

  localparam int BUF_ENTRIES = 2;

endpackage

// >>> include/ram_port_if.sv
interface ram_port_if #(
  parameter int AW = 15,
  parameter int DW = 32
);
  logic          en;
  logic          we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport ctrl
  (
    output en,
    output we,
    output addr,
    output wdata,
    input  rdata
  );
  modport mem
  (
    input  en,
    input  we,
    input  addr,
    input  wdata,
    output rdata
  );
endinterface

// >>> core/queue_ram.sv
module queue_ram #(
  parameter int WORDS = 24576,
  parameter int AW    = 15,
  parameter int DW    = 32
)(
  input wire logic mclk,
  ram_port_if.mem  port
);

  logic [DW-1:0] mem_ff [WORDS];
  logic [DW-1:0] rdata_ff;

  // Read data registered: answer one cycle after the enable
  always_ff @(posedge mclk)
  begin
    if (port.en && port.we)
      mem_ff[port.addr] <= port.wdata;
    if (port.en && !port.we)
      rdata_ff <= mem_ff[port.addr];
  end

  assign port.rdata = rdata_ff;

endmodule

// >>> core/host_iop_message_unit.sv
// Notes on behaviour
// - The doorbell moves one 32-bit word per message in either direction.
// - A host doorbell write raises a maskable interrupt to the io_processor, which reads it.
// - An io_processor doorbell write raises a maskable host interrupt; the host reads it.
// - Two message queues of 32-bit entries: requests to the device, replies to the host.
// - The request queue is the request post FIFO alone.
// - The reply queue is a reply post FIFO plus a reply free FIFO of frame addresses.
// - A successful completion posts a context reply holding the message context.
// - A failure pops a free frame address, writes the error there, then posts the address.
// - All queue storage lives in the shared RAM.
// - The shared RAM is 96 Kbyte and also holds firmware and non-DMA queue traffic.
// - Host reply interrupts are coalesced so several completions need fewer interrupts.
// - The host register set decodes in memory space 0 and in the I/O window alike.
module host_iop_message_unit
  import msg_unit_pkg::*;
#(
  parameter int RAM_WORDS = RAM_WORDS_DEF,
  parameter int QDEPTH    = Q_DEPTH_DEF
)(
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic                         hst_valid,
  output wire logic                         hst_ready,
  input  wire logic                         hst_write,
  input  wire logic                         hst_mem_sel,
  input  wire logic                         hst_io_sel,
  input  wire logic [7:0]                   hst_offset,
  input  wire logic [31:0]                  hst_wdata,
  output wire logic                         hst_rvalid,
  input  wire logic                         hst_rready,
  output wire logic [31:0]                  hst_rdata,
  output wire logic                         host_irq,
  input  wire logic                         iop_valid,
  output wire logic                         iop_ready,
  input  wire logic                         iop_write,
  input  wire logic                         iop_ram_sel,
  input  wire logic [$clog2(RAM_WORDS)-1:0] iop_ram_addr,
  input  wire logic [7:0]                   iop_offset,
  input  wire logic [31:0]                  iop_wdata,
  output wire logic                         iop_rvalid,
  output wire logic [31:0]                  iop_rdata,
  output wire logic                         iop_irq
);

  localparam int RAM_AW = $clog2(RAM_WORDS);
  localparam int QAW    = $clog2(QDEPTH);
  localparam int TCW    = $clog2(TICK_CYC);
  localparam logic [RAM_AW-1:0] QBASE  = RAM_AW'(RAM_WORDS - QUEUE_SLOTS * QDEPTH);
  localparam logic [QAW:0]      QFULL  = (QAW+1)'(QDEPTH);
  localparam logic [TCW-1:0]    TICK_LAST = TCW'(TICK_CYC - 1);

  ram_port_if #(.AW(RAM_AW), .DW(DATA_W)) ram ();

  queue_ram #(.WORDS(RAM_WORDS), .AW(RAM_AW), .DW(DATA_W)) u_ram
  (
    .mclk (mclk),
    .port (ram.mem)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Arbitration: one operation per cycle keeps every update exclusive

  logic            turn_ff;
  logic            h_rd_ff;
  logic            h_ram_ff;
  logic [31:0]     h_regq_ff;
  logic [31:0]     buf_ff [BUF_ENTRIES];
  logic [1:0]      cnt_ff;
  logic            head_ff;

  wire h_room  = (cnt_ff == 2'h0) || (cnt_ff == 2'h1 && !h_rd_ff);
  wire h_ok    = hst_valid && (hst_write || h_room);
  wire grant_h = h_ok && (!iop_valid || turn_ff);
  wire grant_i = iop_valid && !grant_h;

  assign hst_ready = grant_h;
  assign iop_ready = grant_i;

  //////////////////////////////////////////////////////////////////////////////
  // Decode

  wire h_hit = hst_mem_sel || hst_io_sel;
  wire h_wr  = grant_h && h_hit && hst_write;
  wire h_rd  = grant_h && !hst_write;
  wire h_db  = h_hit && hst_offset == HOFF_DOORBELL;
  wire h_st  = h_hit && hst_offset == HOFF_STATUS;
  wire h_msk = h_hit && hst_offset == HOFF_MASK;
  wire h_rq  = h_hit && hst_offset == HOFF_REQ_POST;
  wire h_rp  = h_hit && hst_offset == HOFF_REPLY_POST;
  wire h_rf  = h_hit && hst_offset == HOFF_REPLY_FREE;
  wire h_co  = h_hit && hst_offset == HOFF_COALESCE;

  wire i_raw = grant_i && iop_ram_sel;
  wire i_wr  = grant_i && !iop_ram_sel && iop_write;
  wire i_rd  = grant_i && !iop_ram_sel && !iop_write;
  wire i_db  = iop_offset == IOFF_DOORBELL;
  wire i_st  = iop_offset == IOFF_STATUS;
  wire i_msk = iop_offset == IOFF_MASK;
  wire i_rq  = iop_offset == IOFF_REQ_POST;
  wire i_ctx = iop_offset == IOFF_REPLY_CTX;
  wire i_adr = iop_offset == IOFF_REPLY_ADDR;
  wire i_rf  = iop_offset == IOFF_REPLY_FREE;
  wire i_lv  = iop_offset == IOFF_LEVELS;

  //////////////////////////////////////////////////////////////////////////////
  // Queue pointers; full writes are dropped, empty reads answer all ones

  logic [QAW:0] wp_ff [NUM_QUEUES];
  logic [QAW:0] rp_ff [NUM_QUEUES];
  logic [QAW:0] lvl   [NUM_QUEUES];
  logic         full  [NUM_QUEUES];
  logic         empty [NUM_QUEUES];
  logic [NUM_QUEUES-1:0] push;
  logic [NUM_QUEUES-1:0] pop;

  assign push[Q_REQ_POST]   = h_wr && h_rq && !full[Q_REQ_POST];
  assign pop[Q_REQ_POST]    = i_rd && i_rq && !empty[Q_REQ_POST];
  assign push[Q_REPLY_POST] = i_wr && (i_ctx || i_adr) && !full[Q_REPLY_POST];
  assign pop[Q_REPLY_POST]  = h_rd && h_rp && !empty[Q_REPLY_POST];
  assign push[Q_REPLY_FREE] = h_wr && h_rf && !full[Q_REPLY_FREE];
  assign pop[Q_REPLY_FREE]  = i_rd && i_rf && !empty[Q_REPLY_FREE];

  for (genvar q = 0; q < NUM_QUEUES; q++)
  begin : g_queue
    assign lvl[q]   = wp_ff[q] - rp_ff[q];
    assign full[q]  = lvl[q] == QFULL;
    assign empty[q] = lvl[q] == '0;

    always_ff @(posedge mclk)
    begin
      if (rst)
      begin
        wp_ff[q] <= '0;
        rp_ff[q] <= '0;
      end
      else
      begin
        if (push[q])
          wp_ff[q] <= wp_ff[q] + 1'b1;
        if (pop[q])
          rp_ff[q] <= rp_ff[q] + 1'b1;
      end
    end
  end

  // Queue slots sit in one block at the top of the shared RAM
  wire [1:0] qsel = (push[Q_REPLY_POST] || pop[Q_REPLY_POST]) ? Q_REPLY_POST :
                    (push[Q_REPLY_FREE] || pop[Q_REPLY_FREE]) ? Q_REPLY_FREE : Q_REQ_POST;
  wire [QAW-1:0] qptr = (|push) ? wp_ff[qsel][QAW-1:0] : rp_ff[qsel][QAW-1:0];

  // Address replies carry the frame address halved with the type bit set
  wire [31:0] reply_desc = i_adr ? {1'b1, iop_wdata[31:1]}
                                 : {1'b0, iop_wdata[REPLY_TYPE_BIT-1:0]};

  assign ram.en    = (|push) || (|pop) || i_raw;
  assign ram.we    = (|push) || (i_raw && iop_write);
  assign ram.addr  = i_raw ? iop_ram_addr : QBASE + RAM_AW'({qsel, qptr});
  assign ram.wdata = i_raw ? iop_wdata : push[Q_REPLY_POST] ? reply_desc : hst_wdata;

  //////////////////////////////////////////////////////////////////////////////
  // Doorbell, masks and pending flags

  logic [31:0] doorbell_ff;
  logic        iop_db_pend_ff;
  logic        host_db_pend_ff;
  logic        reply_pend_ff;
  logic [1:0]  hmask_ff;
  logic [1:0]  imask_ff;
  logic [15:0] coal_ff;

  wire h_db_wr = h_wr && h_db;
  wire i_db_wr = i_wr && i_db;

  // Set wins over a clear in the same cycle
  wire nxt_iop_db_pend  = h_db_wr || (iop_db_pend_ff &&
                          !(i_wr && i_st && iop_wdata[ST_DB_BIT]));
  wire nxt_host_db_pend = i_db_wr || (host_db_pend_ff &&
                          !(h_wr && h_st && hst_wdata[ST_DB_BIT]));

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      doorbell_ff     <= '0;
      iop_db_pend_ff  <= 1'b0;
      host_db_pend_ff <= 1'b0;
      hmask_ff        <= '0;
      imask_ff        <= '0;
      coal_ff         <= COAL_RESET;
    end
    else
    begin
      if (h_db_wr)
        doorbell_ff <= hst_wdata;
      else if (i_db_wr)
        doorbell_ff <= iop_wdata;
      iop_db_pend_ff  <= nxt_iop_db_pend;
      host_db_pend_ff <= nxt_host_db_pend;
      if (h_wr && h_msk)
        hmask_ff <= hst_wdata[1:0];
      if (i_wr && i_msk)
        imask_ff <= iop_wdata[1:0];
      if (h_wr && h_co)
        coal_ff <= hst_wdata[15:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reply interrupt coalescing: count threshold or timeout in 1 us ticks

  logic [TCW-1:0]        tick_cnt_ff;
  logic [COAL_FLD_W-1:0] tmr_ff;

  wire tick = tick_cnt_ff == TICK_LAST;
  wire [COAL_FLD_W-1:0] thr = coal_ff[COAL_THR_LSB +: COAL_FLD_W];
  wire [COAL_FLD_W-1:0] tmo = coal_ff[COAL_TMO_LSB +: COAL_FLD_W];
  wire has_reply = !empty[Q_REPLY_POST];
  wire cnt_hit   = has_reply && 16'(lvl[Q_REPLY_POST]) >= 16'(thr);
  wire tmo_hit   = has_reply && tmo != '0 && tmr_ff >= tmo;
  // Pending holds until the host drains the reply post FIFO
  wire nxt_reply_pend = cnt_hit || tmo_hit || (reply_pend_ff && has_reply);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tick_cnt_ff   <= '0;
      tmr_ff        <= '0;
      reply_pend_ff <= 1'b0;
    end
    else
    begin
      tick_cnt_ff   <= tick ? '0 : tick_cnt_ff + 1'b1;
      reply_pend_ff <= nxt_reply_pend;
      if (!has_reply || reply_pend_ff || tmo == '0)
        tmr_ff <= '0;
      else if (tick && tmr_ff != '1)
        tmr_ff <= tmr_ff + 1'b1;
    end
  end

  assign host_irq = (host_db_pend_ff && !hmask_ff[ST_DB_BIT]) ||
                    (reply_pend_ff && !hmask_ff[ST_QUEUE_BIT]);
  assign iop_irq  = (iop_db_pend_ff && !imask_ff[ST_DB_BIT]) ||
                    (!empty[Q_REQ_POST] && !imask_ff[ST_QUEUE_BIT]);

  //////////////////////////////////////////////////////////////////////////////
  // Read answers

  wire [31:0] h_status = {30'h0, reply_pend_ff, host_db_pend_ff};
  wire [31:0] i_status = {30'h0, !empty[Q_REQ_POST], iop_db_pend_ff};
  wire [31:0] h_regval = !h_hit   ? '0 :
                         h_db     ? doorbell_ff :
                         h_st     ? h_status :
                         h_msk    ? 32'(hmask_ff) :
                         h_rq     ? 32'(lvl[Q_REQ_POST]) :
                         h_rp     ? EMPTY_WORD :
                         h_co     ? 32'(coal_ff) : '0;
  wire [31:0] i_regval = i_db ? doorbell_ff :
                         i_st ? i_status :
                         i_msk ? 32'(imask_ff) :
                         (i_rq || i_rf) ? EMPTY_WORD :
                         i_lv ? 32'({lvl[Q_REPLY_FREE], lvl[Q_REPLY_POST], lvl[Q_REQ_POST]}) : '0;

  logic        i_rd_ff;
  logic        i_ram_ff;
  logic [31:0] i_regq_ff;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      turn_ff   <= 1'b0;
      h_rd_ff   <= 1'b0;
      h_ram_ff  <= 1'b0;
      h_regq_ff <= '0;
      i_rd_ff   <= 1'b0;
      i_ram_ff  <= 1'b0;
      i_regq_ff <= '0;
    end
    else
    begin
      if (grant_h || grant_i)
        turn_ff <= grant_i;
      h_rd_ff   <= h_rd;
      h_ram_ff  <= pop[Q_REPLY_POST];
      h_regq_ff <= h_regval;
      i_rd_ff   <= i_rd || (i_raw && !iop_write);
      i_ram_ff  <= pop[Q_REQ_POST] || pop[Q_REPLY_FREE] || i_raw;
      i_regq_ff <= i_regval;
    end
  end

  assign iop_rvalid = i_rd_ff;
  assign iop_rdata  = i_ram_ff ? ram.rdata : i_regq_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Two-entry answer buffer toward the host; credit check keeps it from overrun

  wire        buf_push = h_rd_ff;
  wire        buf_pop  = hst_rvalid && hst_rready;
  wire        tail     = head_ff ^ cnt_ff[0];
  wire [31:0] buf_in   = h_ram_ff ? ram.rdata : h_regq_ff;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      buf_ff[0] <= '0;
      buf_ff[1] <= '0;
      cnt_ff    <= '0;
      head_ff   <= 1'b0;
    end
    else
    begin
      if (buf_push)
        buf_ff[tail] <= buf_in;
      if (buf_pop)
        head_ff <= !head_ff;
      cnt_ff <= cnt_ff + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  assign hst_rvalid = cnt_ff != 2'h0;
  assign hst_rdata  = buf_ff[head_ff];

endmodule

// >>> testbench/msg_unit_props.sv
module msg_unit_props
  import msg_unit_pkg::*;
#(
  parameter int RAM_WORDS = RAM_WORDS_DEF,
  parameter int QDEPTH    = Q_DEPTH_DEF
)(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        hst_valid,
  input wire logic        hst_ready,
  input wire logic        hst_write,
  input wire logic        hst_mem_sel,
  input wire logic        hst_io_sel,
  input wire logic [7:0]  hst_offset,
  input wire logic [31:0] hst_wdata,
  input wire logic        hst_rvalid,
  input wire logic        hst_rready,
  input wire logic [31:0] hst_rdata,
  input wire logic        host_irq,
  input wire logic        iop_valid,
  input wire logic        iop_ready,
  input wire logic        iop_write,
  input wire logic        iop_ram_sel,
  input wire logic [7:0]  iop_offset,
  input wire logic [31:0] iop_wdata,
  input wire logic        iop_rvalid,
  input wire logic        iop_irq
);
  timeunit 1ns;
  timeprecision 100ps;

  // Masks shadowed from the write traffic, since they are not visible at the ports
  logic [1:0] hmask_ff;
  logic [1:0] imask_ff;
  wire        h_wr      = hst_valid && hst_ready && hst_write && (hst_mem_sel || hst_io_sel);
  wire        i_wr      = iop_valid && iop_ready && iop_write && !iop_ram_sel;
  wire        h_rd      = hst_valid && hst_ready && !hst_write;
  wire  [1:0] nxt_hmask = (h_wr && hst_offset == HOFF_MASK) ? hst_wdata[1:0] : hmask_ff;
  wire  [1:0] nxt_imask = (i_wr && iop_offset == IOFF_MASK) ? iop_wdata[1:0] : imask_ff;

  always_ff @(posedge mclk)
  begin
    hmask_ff <= rst ? 2'h0 : nxt_hmask;
    imask_ff <= rst ? 2'h0 : nxt_imask;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  //////////////////////////////////////////////////////////////////////////////
  AST_IOP_ANSWER:
    assert property (iop_rvalid == $past(iop_valid && iop_ready && !iop_write))
    else $error("io answer not one cycle after read");
  AST_HST_LATENCY:
    assert property (h_rd && !hst_rvalid |-> ##2 hst_rvalid)
    else $error("host answer late");
  AST_HST_HOLD:
    assert property (hst_rvalid && !hst_rready |=> hst_rvalid && $stable(hst_rdata))
    else $error("host answer dropped while stalled");
  AST_NO_SEL:
    assert property (h_rd && !hst_mem_sel && !hst_io_sel && !hst_rvalid && !$past(h_rd)
      |-> ##2 hst_rvalid && hst_rdata == 32'h0)
    else $error("unselected read not zero");
  AST_RESET_QUIET:
    assert property ($fell(rst) |-> !host_irq && !iop_irq && !hst_rvalid && !iop_rvalid)
    else $error("outputs active after reset");
  AST_DB_TO_IO:
    assert property (h_wr && hst_offset == HOFF_DOORBELL && !imask_ff[0] |-> ##[1:2] iop_irq)
    else $error("host doorbell raised no io interrupt");
  AST_DB_TO_HOST:
    assert property (i_wr && iop_offset == IOFF_DOORBELL && !hmask_ff[0] |-> ##[1:2] host_irq)
    else $error("io doorbell raised no host interrupt");
  AST_MASKED:
    assert property (hmask_ff == 2'h3 && $past(hmask_ff) == 2'h3 |-> !host_irq)
    else $error("host interrupt while fully masked");
  AST_REQ_IRQ:
    assert property (h_wr && hst_offset == HOFF_REQ_POST && !imask_ff[1] |-> ##[1:2] iop_irq)
    else $error("posted request raised no io interrupt");
endmodule

bind host_iop_message_unit msg_unit_props #(.RAM_WORDS(RAM_WORDS), .QDEPTH(QDEPTH)) props_i (
  .mclk, .rst, .hst_valid, .hst_ready, .hst_write, .hst_mem_sel, .hst_io_sel, .hst_offset,
  .hst_wdata, .hst_rvalid, .hst_rready, .hst_rdata, .host_irq, .iop_valid, .iop_ready,
  .iop_write, .iop_ram_sel, .iop_offset, .iop_wdata, .iop_rvalid, .iop_irq);

// >>> testbench/io_processor_model.sv
module io_processor_model #(
  parameter int AW = 10
)(
  input  wire logic        mclk,
  input  wire logic        iop_ready,
  input  wire logic        iop_rvalid,
  input  wire logic [31:0] iop_rdata,
  output logic             iop_valid,
  output logic             iop_write,
  output logic             iop_ram_sel,
  output logic [AW-1:0]    iop_ram_addr,
  output logic [7:0]       iop_offset,
  output logic [31:0]      iop_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    {iop_valid, iop_write, iop_ram_sel, iop_ram_addr, iop_offset, iop_wdata} = '0;
  end

  // One access at a time; the answer is only there in the cycle after the accept
  task automatic cyc(input logic [AW+41:0] r, output logic [31:0] rd);
    int k;
    @(posedge mclk);
    #1;
    {iop_valid, iop_write, iop_ram_sel, iop_ram_addr, iop_offset, iop_wdata} = {1'h1, r};
    for (k = 0; k <= 50; k++)
    begin
      @(posedge mclk);
      if (iop_ready === 1'h1)
        break;
    end
    host_iop_message_unit_test.tmo(k);
    #1;
    iop_valid = 1'h0;
    iop_wdata = ~iop_wdata;
    rd = (iop_rvalid === 1'h1) ? iop_rdata : 32'hBAD0BAD0;
  endtask
endmodule

// >>> testbench/host_iop_message_unit_test.sv
module host_iop_message_unit_test
  import msg_unit_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  localparam int         RW = 1024;
  localparam int         QD = 4;
  localparam logic [9:0] QB = 10'(RW - 4 * QD);
  localparam int         LW = $clog2(QD) + 1;
  logic        mclk, rst, hst_valid, hst_write, hst_mem_sel, hst_io_sel, hst_rready;
  logic [7:0]  hst_offset;
  logic [31:0] hst_wdata, rd, v, db;
  logic [31:0] reqq[$], repq[$], freeq[$];
  logic [1:0]  sels[3] = '{2'h1, 2'h2, 2'h0};
  wire         hst_ready, hst_rvalid, host_irq, iop_ready, iop_rvalid, iop_irq;
  wire         iop_valid, iop_write, iop_ram_sel;
  wire  [9:0]  iop_ram_addr;
  wire  [7:0]  iop_offset;
  wire  [31:0] hst_rdata, iop_wdata, iop_rdata;
  int          err_count = 0;
  int          n_checks = 0;
  int          i;

  initial
  begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end

  host_iop_message_unit #(.RAM_WORDS(RW), .QDEPTH(QD)) uut (.mclk, .rst, .hst_valid, .hst_ready,
    .hst_write, .hst_mem_sel, .hst_io_sel, .hst_offset, .hst_wdata, .hst_rvalid, .hst_rready,
    .hst_rdata, .host_irq, .iop_valid, .iop_ready, .iop_write, .iop_ram_sel, .iop_ram_addr,
    .iop_offset, .iop_wdata, .iop_rvalid, .iop_rdata, .iop_irq);
  io_processor_model #(.AW(10)) cpu (.mclk, .iop_ready, .iop_rvalid, .iop_rdata, .iop_valid,
    .iop_write, .iop_ram_sel, .iop_ram_addr, .iop_offset, .iop_wdata);

  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tmo(input int k);
    if (k > 50)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask
  // Request is {write, mem_sel, io_sel, offset, data}
  task automatic hreq(input logic [42:0] r);
    tick(1);
    {hst_valid, hst_write, hst_mem_sel, hst_io_sel, hst_offset, hst_wdata} = {1'h1, r};
    hwait();
  endtask
  // Request stays up until the accept edge, never withdrawn
  task automatic hwait();
    int k;
    for (k = 0; k <= 50; k++)
    begin
      @(posedge mclk);
      if (hst_ready === 1'h1)
        break;
    end
    tmo(k);
    #1;
    hst_valid = 1'h0;
    hst_wdata = ~hst_wdata;
  endtask
  task automatic hpop(input logic [31:0] e);
    int k;
    tick(1);
    hst_rready = 1'h1;
    for (k = 0; k <= 50; k++)
    begin
      @(posedge mclk);
      if (hst_rvalid === 1'h1)
        break;
    end
    tmo(k);
    cmp(hst_rdata, e);
    #1;
    hst_rready = 1'h0;
  endtask
  task automatic hrd(input logic [1:0] s, input logic [7:0] o, input logic [31:0] e);
    hreq({1'h0, s, o, 32'h0});
    hpop(e);
  endtask
  task automatic hwr(input logic [7:0] o, input logic [31:0] d);
    hreq({1'h1, 2'h2, o, d});
  endtask
  task automatic ird(input logic [7:0] o, input logic [31:0] e);
    cpu.cyc({2'h0, 10'h0, o, 32'h0}, rd);
    cmp(rd, e);
  endtask
  task automatic iwr(input logic [7:0] o, input logic [31:0] d);
    cpu.cyc({2'h2, 10'h0, o, d}, rd);
  endtask
  task automatic irqs(input logic [1:0] e);
    tick(2);
    cmp({30'h0, host_irq, iop_irq}, {30'h0, e});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {hst_valid, hst_write, hst_mem_sel, hst_io_sel, hst_rready} = 5'h0;
    hst_offset = 8'h0;
    hst_wdata = 32'h0;
    rst = 1'h1;
    v = $urandom(28884);
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'h0;
    v = $urandom();
    hwr(HOFF_DOORBELL, v);
    irqs(2'h1);
    ird(IOFF_DOORBELL, v);
    iwr(IOFF_STATUS, 32'h1);
    irqs(2'h0);
    v = $urandom();
    iwr(IOFF_DOORBELL, v);
    irqs(2'h2);
    hwr(HOFF_MASK, 32'h3);
    irqs(2'h0);
    hwr(HOFF_MASK, 32'h0);
    irqs(2'h2);
    hrd(2'h2, HOFF_DOORBELL, v);
    hwr(HOFF_STATUS, 32'h1);
    irqs(2'h0);
    endt("doorbell");
    // Same offsets through either window; no select must change nothing
    db = v;
    for (i = 0; i < 3; i++)
    begin
      v = $urandom();
      hreq({1'h1, sels[i], HOFF_DOORBELL, v});
      db = (sels[i] != 2'h0) ? v : db;
      hrd({sels[i][0], sels[i][1]}, HOFF_DOORBELL, (sels[i] != 2'h0) ? db : 32'h0);
    end
    hrd(2'h1, HOFF_DOORBELL, db);
    iwr(IOFF_STATUS, 32'h1);
    endt("decode");
    // One past full: the extra descriptor is dropped
    for (i = 0; i <= QD; i++)
    begin
      v = $urandom() & 32'hFFFFFF80;
      hwr(HOFF_REQ_POST, v);
      if (reqq.size() < QD)
        reqq.push_back(v);
    end
    irqs(2'h1);
    hrd(2'h2, HOFF_REQ_POST, 32'(QD));
    cpu.cyc({2'h1, QB, 8'h0, 32'h0}, rd);
    cmp(rd, reqq[0]);
    for (i = 0; i <= QD; i++)
      ird(IOFF_REQ_POST, (reqq.size() > 0) ? reqq.pop_front() : EMPTY_WORD);
    irqs(2'h0);
    endt("request");
    hwr(HOFF_COALESCE, 32'h2);
    for (i = 0; i < 2; i++)
    begin
      freeq.push_back(32'($urandom_range(255)));
      hwr(HOFF_REPLY_FREE, freeq[i]);
    end
    v = $urandom();
    iwr(IOFF_REPLY_CTX, v);
    repq.push_back({1'h0, v[30:0]});
    irqs(2'h0);
    ird(IOFF_REPLY_FREE, freeq[0]);
    v = $urandom();
    cpu.cyc({2'h3, freeq[0][9:0], 8'h0, v}, rd);
    iwr(IOFF_REPLY_ADDR, freeq[0]);
    repq.push_back({1'h1, freeq[0][31:1]});
    irqs(2'h2);
    cpu.cyc({2'h1, freeq[0][9:0], 8'h0, 32'h0}, rd);
    cmp(rd, v);
    // Host stalls: two answers fill the buffer, a third read must wait
    hreq({1'h0, 2'h2, HOFF_REPLY_POST, 32'h0});
    hreq({1'h0, 2'h2, HOFF_REPLY_POST, 32'h0});
    tick(1);
    {hst_valid, hst_write, hst_mem_sel, hst_offset} = {1'h1, 1'h0, 1'h1, HOFF_REPLY_POST};
    tick(3);
    cmp(32'(hst_ready), 32'h0);
    hpop(repq.pop_front());
    hwait();
    hpop(repq.pop_front());
    hpop(EMPTY_WORD);
    hrd(2'h2, HOFF_REPLY_POST, EMPTY_WORD);
    irqs(2'h0);
    endt("reply");
    // Threshold out of reach: only the two-tick timeout may interrupt
    hwr(HOFF_COALESCE, 32'h0203);
    hrd(2'h1, HOFF_COALESCE, 32'h0203);
    v = $urandom();
    iwr(IOFF_REPLY_CTX, v);
    irqs(2'h0);
    ird(IOFF_LEVELS, 32'((1 << (2 * LW)) | (1 << LW)));
    tick(200);
    irqs(2'h0);
    tick(300);
    irqs(2'h2);
    hrd(2'h2, HOFF_REPLY_POST, {1'h0, v[30:0]});
    irqs(2'h0);
    endt("coalesce");
    tally_and_finish();
  end
endmodule
